//--- hw/alr_consts.svh
// Purpose: Shared constants of the four-channel alarm state block.
// Assumes: One 100 MHz clock; values are signed engineering units.
// Notes: Definitions only.
//
// Contract
// - Non-latching/event alarm active at power loss re-arms blocking if blocking set.
// - Non-latching/event active alarm without blocking returns active.
// - Non-latching/event alarm that went safe while off returns inactive.
// - Auto-latching alarm re-arms blocking only if acknowledged before power loss.
// - Auto-latching active alarm returns active if unblocked or unacknowledged.
// - Auto-latching gone safe: inactive if acknowledged, else safe unacknowledged.
// - Latching alarm safe but unacknowledged returns safe but unacknowledged.
// - Manual-latching never re-arms blocking; active alarm returns active.
// - Manual-latching gone safe returns safe unacknowledged regardless of acknowledge.
// - Four independent channels with own settings and output status.
// - Kind none hides settings and stops the channel.
// - Kinds: none, high, low, deviation high/low/band, rate rise/fall 1-9999.
// - Trip threshold takes any instrument value, defaults to zero.
// - Each channel reports a read-only output status, off or on.
// - Clear margin configurable from 0 to 9999.
// - Four latch policies; event-only lights no beacon but allows messages.
// - Blocking holds alarm off until process first reaches a safe state.
// - A setpoint change re-arms a blocking alarm.
// - Auto-latching needs acknowledge, accepted while condition still present.
// - Manual-latching stays active until cleared and acknowledged after clearing.
`ifndef ALR_CONSTS_SVH
`define ALR_CONSTS_SVH

`define ALR_NCH 4
`define ALR_AW 2
`define ALR_LAST_CH 2'h3
`define ALR_VW 16
`define ALR_XW 18
`define ALR_MW 14
`define ALR_THR_RST 16'sh0000
`define ALR_MARGIN_RST 14'h0000
`define ALR_MARGIN_MAX 14'h270F
`define ALR_RATE_MIN 16'sh0001
`define ALR_RATE_MAX 16'sh270F

`endif

//--- hw/alr_pkg.sv
// Purpose: Types of the alarm state block.
// Assumes: Constants come from the shared header.
// Notes: Kind and policy encodings follow declaration order.
`include "alr_consts.svh"
package alr_pkg;
    typedef enum logic [2:0] {
        KIND_NONE, KIND_FS_HIGH, KIND_FS_LOW, KIND_DEV_HIGH,
        KIND_DEV_LOW, KIND_DEV_BAND, KIND_RATE_RISE, KIND_RATE_FALL
    } alr_kind_t;
    typedef enum logic [1:0] {
        LATCH_NONE, LATCH_AUTO, LATCH_MANUAL, LATCH_EVENT
    } alr_latch_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_SAFE_UNACK} alr_state_t;
    typedef enum logic [1:0] {RS_CFG, RS_READ, RS_APPLY, RS_RUN} alr_rs_t;
    typedef struct packed {
        logic active;
        logic safe_unack;
        logic acked;
        logic armed;
    } alr_nv_rec_t;
endpackage : alr_pkg

//--- hw/alr_nv_if.sv
// Purpose: Port bundle between the alarm core and its retained store.
// Assumes: Read data appear one clock after the address.
// Notes: One write port, one read port.
`timescale 1ns/1ps
`include "alr_consts.svh"
interface alr_nv_if;
    logic we;
    logic [`ALR_AW-1:0] waddr;
    logic [`ALR_AW-1:0] raddr;
    alr_pkg::alr_nv_rec_t wdata;
    alr_pkg::alr_nv_rec_t rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : alr_nv_if

//--- hw/alr_nv_mem.sv
// Purpose: Retained per-channel alarm state store.
// Assumes: Storage cells are backed by a supply that survives power loss.
// Notes: Only the read register is reset; the cells keep their content.
`timescale 1ns/1ps
`include "alr_consts.svh"
module alr_nv_mem (
    input wire logic mclk_i,
    input wire logic reset_i,
    alr_nv_if.mem nv
);
    import alr_pkg::*;

    alr_nv_rec_t cell_q [`ALR_NCH];

    // Resetting the cells would destroy the state that start-up must restore.
    always_ff @(posedge mclk_i) begin
        if (nv.we) begin
            cell_q[nv.waddr] <= nv.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            nv.rdata <= '0;
        end else begin
            nv.rdata <= cell_q[nv.raddr];
        end
    end
endmodule : alr_nv_mem

//--- hw/alr_cond.sv
// Purpose: Trip and clear evaluation of one alarm channel.
// Assumes: Rate input is already in units per minute.
// Notes: Purely combinational; the caller holds the hysteresis state.
`timescale 1ns/1ps
`include "alr_consts.svh"
module alr_cond (
    input wire alr_pkg::alr_kind_t kind_i,
    input wire logic signed [`ALR_VW-1:0] thr_i,
    input wire logic [`ALR_MW-1:0] margin_i,
    input wire logic signed [`ALR_VW-1:0] pv_i,
    input wire logic signed [`ALR_VW-1:0] sp_i,
    input wire logic signed [`ALR_VW-1:0] rate_i,
    output logic trip_o,
    output logic clear_o
);
    import alr_pkg::*;

    logic signed [`ALR_XW-1:0] pv_x, sp_x, rt_x, th_x, mg_x, dev_x, x, t;
    logic used;

    assign pv_x = `ALR_XW'(pv_i);
    assign sp_x = `ALR_XW'(sp_i);
    assign rt_x = `ALR_XW'(rate_i);
    assign th_x = `ALR_XW'(thr_i);
    assign mg_x = $signed({4'h0, margin_i});
    assign dev_x = pv_x - sp_x;

    // Every kind but KIND_NONE is folded onto "x above t" so one comparator pair serves all.
    always_comb begin
        x = '0;
        t = '0;
        used = 1'b1;
        case (kind_i)
            KIND_FS_HIGH: begin x = pv_x; t = th_x; end
            KIND_FS_LOW: begin x = -pv_x; t = -th_x; end
            KIND_DEV_HIGH: begin x = dev_x; t = th_x; end
            KIND_DEV_LOW: begin x = -dev_x; t = th_x; end
            KIND_DEV_BAND: begin x = (dev_x < 0) ? -dev_x : dev_x; t = th_x; end
            KIND_RATE_RISE: begin x = rt_x; t = th_x; end
            KIND_RATE_FALL: begin x = -rt_x; t = th_x; end
            default: used = 1'b0;
        endcase
        trip_o = used && (x > t);
        clear_o = !used || (x <= t - mg_x);
    end
endmodule : alr_cond

//--- hw/alr_top.sv
// Purpose: Four-channel alarm state logic with latching, blocking and power-return restore.
// Assumes: Configuration is written after reset and then cfg_done_i is raised and held.
// Notes: ack_i and cfg_wr_i are one-cycle pulses per channel.
`timescale 1ns/1ps
`include "alr_consts.svh"
module alr_top (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic signed [`ALR_VW-1:0] pv_i,
    input wire logic signed [`ALR_VW-1:0] sp_i,
    input wire logic signed [`ALR_VW-1:0] rate_i,
    input wire logic [`ALR_NCH-1:0] ack_i,
    input wire logic [`ALR_NCH-1:0] cfg_wr_i,
    input wire alr_pkg::alr_kind_t cfg_kind_i,
    input wire logic signed [`ALR_VW-1:0] cfg_thr_i,
    input wire logic [`ALR_MW-1:0] cfg_margin_i,
    input wire alr_pkg::alr_latch_t cfg_latch_i,
    input wire logic cfg_blk_i,
    input wire logic cfg_done_i,
    input wire logic nv_valid_i,
    output logic [`ALR_NCH-1:0] alarm_output_state_o,
    output logic [`ALR_NCH-1:0] beacon_flash_o,
    output logic [`ALR_NCH-1:0] beacon_steady_o,
    output logic [`ALR_NCH-1:0] message_o,
    output logic [`ALR_NCH-1:0] settings_visible_o,
    output logic [`ALR_NCH-1:0] suppress_armed_o,
    output logic restore_busy_o
);
    import alr_pkg::*;

    alr_nv_if nv ();

    alr_rs_t rs_q;
    logic [`ALR_AW-1:0] rs_ch_q;
    logic [`ALR_AW-1:0] wr_q;
    logic signed [`ALR_VW-1:0] sp_q;
    logic sp_chg;
    logic running;
    alr_nv_rec_t save_rec;

    alr_state_t st_q [`ALR_NCH];
    logic acked_q [`ALR_NCH];
    logic armed_q [`ALR_NCH];

    logic [`ALR_NCH-1:0] on_w;
    logic [`ALR_NCH-1:0] flash_w;
    logic [`ALR_NCH-1:0] steady_w;
    logic [`ALR_NCH-1:0] vis_w;
    logic [`ALR_NCH-1:0] arm_w;

    assign running = (rs_q == RS_RUN);
    // A setpoint change is any difference from the value seen one clock earlier.
    assign sp_chg = (sp_i != sp_q);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sp_q <= `ALR_THR_RST;
        end else begin
            sp_q <= sp_i;
        end
    end

    // Start-up walk: wait for configuration, then read back each channel's record once if nv_valid_i is set.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rs_q <= RS_CFG;
            rs_ch_q <= '0;
        end else begin
            case (rs_q)
                RS_CFG: begin
                    if (cfg_done_i) begin
                        rs_q <= nv_valid_i ? RS_READ : RS_RUN;
                    end
                end
                RS_READ: begin
                    rs_q <= RS_APPLY;
                end
                RS_APPLY: begin
                    if (rs_ch_q == `ALR_LAST_CH) begin
                        rs_q <= RS_RUN;
                    end else begin
                        rs_ch_q <= rs_ch_q + 1'b1;
                        rs_q <= RS_READ;
                    end
                end
                RS_RUN: begin
                    rs_q <= RS_RUN;
                end
                default: begin
                    rs_q <= RS_CFG;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_q <= '0;
        end else if (running) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    // Saving stops until restore is done so a stale record is never overwritten early.
    assign nv.we = running;
    assign nv.waddr = wr_q;
    assign nv.raddr = rs_ch_q;

    // record of the channel under save
    always_comb begin
        save_rec = '0;
        save_rec.active = (st_q[wr_q] == ST_ACTIVE);
        save_rec.safe_unack = (st_q[wr_q] == ST_SAFE_UNACK);
        save_rec.acked = acked_q[wr_q];
        save_rec.armed = armed_q[wr_q];
    end

    assign nv.wdata = save_rec;

    alr_nv_mem u_nv (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .nv(nv)
    );

    for (genvar g = 0; g < `ALR_NCH; g++) begin : g_ch
        alr_kind_t kind_q;
        alr_latch_t latch_q;
        logic signed [`ALR_VW-1:0] thr_q;
        logic signed [`ALR_VW-1:0] thr_ld;
        logic [`ALR_MW-1:0] margin_q;
        logic blk_q;
        logic cond_q;
        logic trip_w;
        logic clr_w;
        logic cond_now;
        logic off;
        logic latching;
        logic apply;
        logic cold;
        logic is_rate;

        assign is_rate = (cfg_kind_i == KIND_RATE_RISE) || (cfg_kind_i == KIND_RATE_FALL);

        always_comb begin
            thr_ld = cfg_thr_i;
            if (is_rate && (cfg_thr_i < `ALR_RATE_MIN)) begin
                thr_ld = `ALR_RATE_MIN;
            end else if (is_rate && (cfg_thr_i > `ALR_RATE_MAX)) begin
                thr_ld = `ALR_RATE_MAX;
            end
        end

        always_ff @(posedge mclk_i) begin
            if (reset_i) begin
                kind_q <= KIND_NONE;
                latch_q <= LATCH_NONE;
                thr_q <= `ALR_THR_RST;
                margin_q <= `ALR_MARGIN_RST;
                blk_q <= 1'b0;
            end else if (cfg_wr_i[g]) begin
                kind_q <= cfg_kind_i;
                latch_q <= cfg_latch_i;
                thr_q <= thr_ld;
                margin_q <= (cfg_margin_i > `ALR_MARGIN_MAX) ? `ALR_MARGIN_MAX : cfg_margin_i;
                blk_q <= cfg_blk_i;
            end
        end

        alr_cond u_cond (
            .kind_i(kind_q),
            .thr_i(thr_q),
            .margin_i(margin_q),
            .pv_i(pv_i),
            .sp_i(sp_i),
            .rate_i(rate_i),
            .trip_o(trip_w),
            .clear_o(clr_w)
        );

        assign off = (kind_q == KIND_NONE);
        assign latching = (latch_q == LATCH_AUTO) || (latch_q == LATCH_MANUAL);
        assign apply = (rs_q == RS_APPLY) && (rs_ch_q == `ALR_AW'(g));
        // Without a valid record, start-up arms blocking straight from the configuration, except on manual-latching channels.
        assign cold = (rs_q == RS_CFG) && cfg_done_i && !nv_valid_i;
        assign cond_now = trip_w || (cond_q && !clr_w);

        // The hysteresis memory is dropped with the kind, so a re-enabled channel starts clean.
        always_ff @(posedge mclk_i) begin
            if (reset_i || off) begin
                cond_q <= 1'b0;
            end else begin
                cond_q <= cond_now;
            end
        end

        always_ff @(posedge mclk_i) begin
            if (reset_i || off) begin
                st_q[g] <= ST_IDLE;
                acked_q[g] <= 1'b0;
                armed_q[g] <= 1'b0;
            end else if (apply) begin
                armed_q[g] <= 1'b0;
                acked_q[g] <= 1'b0;
                st_q[g] <= ST_IDLE;
                if (nv.rdata.active) begin
                    case (latch_q)
                        LATCH_AUTO: begin
                            if (blk_q && nv.rdata.acked) begin
                                armed_q[g] <= 1'b1;
                            end else if (cond_now) begin
                                st_q[g] <= ST_ACTIVE;
                                acked_q[g] <= nv.rdata.acked;
                            end else if (!nv.rdata.acked) begin
                                st_q[g] <= ST_SAFE_UNACK;
                            end
                        end
                        LATCH_MANUAL: begin
                            if (cond_now) begin
                                st_q[g] <= ST_ACTIVE;
                                acked_q[g] <= nv.rdata.acked;
                            end else begin
                                st_q[g] <= ST_SAFE_UNACK;
                            end
                        end
                        default: begin
                            if (blk_q) begin
                                armed_q[g] <= 1'b1;
                            end else if (cond_now) begin
                                st_q[g] <= ST_ACTIVE;
                                acked_q[g] <= nv.rdata.acked;
                            end
                        end
                    endcase
                end else if (nv.rdata.safe_unack && latching) begin
                    st_q[g] <= ST_SAFE_UNACK;
                end else begin
                    armed_q[g] <= blk_q && (latch_q != LATCH_MANUAL);
                end
            end else if (cold) begin
                armed_q[g] <= blk_q && (latch_q != LATCH_MANUAL);
            end else if (running) begin
                if (blk_q && sp_chg) begin
                    armed_q[g] <= 1'b1;
                end else if (clr_w) begin
                    armed_q[g] <= 1'b0;
                end
                case (st_q[g])
                    ST_IDLE: begin
                        if (cond_now && !armed_q[g]) begin
                            st_q[g] <= ST_ACTIVE;
                            acked_q[g] <= 1'b0;
                        end
                    end
                    ST_ACTIVE: begin
                        if (!cond_now) begin
                            if (latch_q == LATCH_MANUAL) begin
                                st_q[g] <= ST_SAFE_UNACK;
                            end else if (latch_q == LATCH_AUTO && !acked_q[g] && !ack_i[g]) begin
                                st_q[g] <= ST_SAFE_UNACK;
                            end else begin
                                st_q[g] <= ST_IDLE;
                                acked_q[g] <= 1'b0;
                            end
                        end else if (ack_i[g] && latch_q != LATCH_MANUAL) begin
                            acked_q[g] <= 1'b1;
                        end
                    end
                    ST_SAFE_UNACK: begin
                        if (cond_now) begin
                            st_q[g] <= ST_ACTIVE;
                        end else if (ack_i[g]) begin
                            st_q[g] <= ST_IDLE;
                            acked_q[g] <= 1'b0;
                        end
                    end
                    default: begin
                        st_q[g] <= ST_IDLE;
                    end
                endcase
            end
        end

        assign on_w[g] = (st_q[g] != ST_IDLE);
        assign flash_w[g] = on_w[g] && !acked_q[g] && (latch_q != LATCH_EVENT);
        assign steady_w[g] = on_w[g] && acked_q[g] && (latch_q != LATCH_EVENT);
        assign vis_w[g] = !off;
        assign arm_w[g] = armed_q[g];
    end

    // Outputs are registered so the panel never sees decode glitches.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            alarm_output_state_o <= '0;
            message_o <= '0;
            settings_visible_o <= '0;
            suppress_armed_o <= '0;
            restore_busy_o <= 1'b1;
        end else begin
            alarm_output_state_o <= on_w;
            message_o <= on_w;
            settings_visible_o <= vis_w;
            suppress_armed_o <= arm_w;
            restore_busy_o <= !running;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            beacon_flash_o <= '0;
            beacon_steady_o <= '0;
        end else begin
            beacon_flash_o <= flash_w;
            beacon_steady_o <= steady_w;
        end
    end
endmodule : alr_top

//--- sim/alr_top_properties.sv
// Purpose: Port-level checks of the four-channel alarm state block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Restore windows allow two or three cycles of slack, since the walk is only fixed per channel.
`timescale 1ns/1ps
`include "alr_consts.svh"
module alr_top_properties (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [`ALR_NCH-1:0] cfg_wr_i,
    input wire alr_pkg::alr_kind_t cfg_kind_i,
    input wire logic cfg_done_i,
    input wire logic nv_valid_i,
    input wire logic [`ALR_NCH-1:0] alarm_output_state_o,
    input wire logic [`ALR_NCH-1:0] beacon_flash_o,
    input wire logic [`ALR_NCH-1:0] beacon_steady_o,
    input wire logic [`ALR_NCH-1:0] message_o,
    input wire logic [`ALR_NCH-1:0] settings_visible_o,
    input wire logic [`ALR_NCH-1:0] suppress_armed_o,
    input wire logic restore_busy_o
);
    import alr_pkg::*;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_walk;
        restore_busy_o [*8];
    endsequence
    sequence s_quick;
        ##[1:4] !restore_busy_o;
    endsequence
    chk_reset_quiet: assert property (
        $fell(reset_i) |-> restore_busy_o && (alarm_output_state_o | suppress_armed_o) == 4'h0)
        else $error("outputs not quiet after reset");
    chk_msg_follows: assert property (
        message_o == alarm_output_state_o)
        else $error("message differs from output state");
    chk_beacon_exclusive: assert property (
        (beacon_flash_o & beacon_steady_o) == 4'h0)
        else $error("beacon both flashing and steady");
    chk_beacon_needs_alarm: assert property (
        ((beacon_flash_o | beacon_steady_o) & ~alarm_output_state_o) == 4'h0)
        else $error("beacon lit without alarm");
    chk_hidden_quiet: assert property (
        (alarm_output_state_o & ~settings_visible_o & ~$past(settings_visible_o)
            & ~$past(settings_visible_o, 2)) == 4'h0)
        else $error("unconfigured channel shows alarm");
    chk_visible_follows: assert property (
        cfg_wr_i[0] |-> ##2 settings_visible_o[0] == ($past(cfg_kind_i, 2) != KIND_NONE))
        else $error("settings visibility wrong after write");
    chk_busy_holds: assert property (
        restore_busy_o && !cfg_done_i |=> restore_busy_o)
        else $error("restore ended before configuration");
    chk_cold_restore: assert property (
        $rose(cfg_done_i) && !nv_valid_i |-> s_quick)
        else $error("cold start did not finish in time");
    chk_warm_restore: assert property (
        $rose(cfg_done_i) && nv_valid_i |-> ##1 s_walk ##[1:3] !restore_busy_o)
        else $error("warm restore walk has wrong length");
    chk_block_holds: assert property (
        (alarm_output_state_o & ~$past(alarm_output_state_o) & $past(suppress_armed_o)) == 4'h0)
        else $error("alarm rose while blocking armed");
endmodule : alr_top_properties

//--- sim/tb_alr_top.sv
// Purpose: Self-checking bench of the four-channel alarm state block.
// Assumes: Every channel trips above 100 with margin 2; channel n uses latch policy n.
// Notes: A warm restart stands for a power cycle, as reset leaves the retained store alone.
`timescale 1ns/1ps
`include "alr_consts.svh"
module tb_alr_top;
    import alr_pkg::*;
    logic mclk_i;
    logic reset_i;
    logic signed [`ALR_VW-1:0] pv_i;
    logic signed [`ALR_VW-1:0] sp_i;
    logic signed [`ALR_VW-1:0] rate_i;
    logic signed [`ALR_VW-1:0] cfg_thr_i;
    logic [`ALR_MW-1:0] cfg_margin_i;
    logic [3:0] ack_i;
    logic [3:0] cfg_wr_i;
    alr_kind_t cfg_kind_i;
    alr_latch_t cfg_latch_i;
    logic cfg_blk_i;
    logic cfg_done_i;
    logic nv_valid_i;
    logic [3:0] state, flash, steady, msg, shown, armed;
    logic busy;
    int fails = 0;
    int tests_run = 0;

    alr_top i_dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .pv_i(pv_i), .sp_i(sp_i), .rate_i(rate_i),
        .ack_i(ack_i), .cfg_wr_i(cfg_wr_i), .cfg_kind_i(cfg_kind_i), .cfg_thr_i(cfg_thr_i),
        .cfg_margin_i(cfg_margin_i), .cfg_latch_i(cfg_latch_i), .cfg_blk_i(cfg_blk_i),
        .cfg_done_i(cfg_done_i), .nv_valid_i(nv_valid_i), .alarm_output_state_o(state),
        .beacon_flash_o(flash), .beacon_steady_o(steady), .message_o(msg),
        .settings_visible_o(shown), .suppress_armed_o(armed), .restore_busy_o(busy)
    );

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : step

    // Reads happen a little after the edge so that the edge's updates have landed.
    task automatic settle(input int n);
        step(n);
        #1;
    endtask : settle

    task automatic cmp(input logic [3:0] got, input logic [3:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic drive_pv(input logic signed [15:0] v);
        step(1);
        pv_i <= v;
        settle(3);
    endtask : drive_pv

    task automatic ack(input logic [3:0] m);
        step(1);
        ack_i <= m;
        step(1);
        ack_i <= 4'h0;
        settle(3);
    endtask : ack

    task automatic cfg_all(input logic blk);
        for (int ch = 0; ch < 4; ch++) begin
            step(1);
            cfg_wr_i <= 4'h1 << ch;
            cfg_kind_i <= KIND_FS_HIGH;
            cfg_latch_i <= alr_latch_t'(2'(ch));
            cfg_blk_i <= blk;
        end
        step(1);
        cfg_wr_i <= 4'h0;
    endtask : cfg_all

    // The value pv holds while reset is applied is what the process did while power was off.
    task automatic restart(input logic warm, input logic blk, input int n, input logic signed [15:0] pv);
        step(1);
        reset_i <= 1'b1;
        cfg_done_i <= 1'b0;
        pv_i <= pv;
        step(n);
        reset_i <= 1'b0;
        nv_valid_i <= warm;
        cfg_all(blk);
        step(1);
        cfg_done_i <= 1'b1;
        for (int k = 0; k < 40 && busy !== 1'b0; k++) begin
            settle(1);
        end
        cmp({3'h0, busy}, 4'h0, "restore end");
        settle(2);
    endtask : restart

    task automatic t_latch();
        drive_pv(16'sh0065);
        cmp(state, 4'hF, "all tripped");
        cmp(flash, 4'h7, "event beacon dark");
        cmp(msg, 4'hF, "event still shows message");
        ack(4'h7);
        cmp(steady, 4'h3, "steady after ack");
        cmp(flash, 4'h4, "manual ack refused");
        drive_pv(16'sh0063);
        cmp(state, 4'hF, "inside margin");
        drive_pv(16'sh0062);
        cmp(state, 4'h4, "cleared at margin");
        ack(4'h4);
        cmp(state, 4'h0, "manual reset");
    endtask : t_latch

    task automatic t_power();
        drive_pv(16'sh0065);
        ack(4'h2);
        step(8);
        restart(1'b1, 1'b0, 2, 16'sh0065);
        cmp(state, 4'hF, "active kept");
        cmp(steady, 4'h2, "ack kept");
        cmp(flash, 4'h5, "unacked kept");
        step(8);
        restart(1'b1, 1'b0, 2, 16'sh0032);
        cmp(state, 4'h4, "gone safe while off");
        step(8);
        restart(1'b1, 1'b0, 2, 16'sh0032);
        cmp(flash, 4'h4, "safe unacked kept");
    endtask : t_power

    task automatic t_block();
        drive_pv(16'sh0065);
        ack(4'h2);
        step(8);
        restart(1'b1, 1'b1, 2, 16'sh0065);
        cmp(state, 4'h4, "blocked after restart");
        cmp(armed, 4'hB, "blocking re-armed");
        settle(10);
        cmp(state, 4'h4, "held off while armed");
        drive_pv(16'sh0032);
        cmp(armed, 4'h0, "safe disarms");
        drive_pv(16'sh0065);
        cmp(state, 4'hF, "trips after safe");
        step(1);
        sp_i <= 16'sh0005;
        settle(3);
        cmp(armed, 4'hF, "setpoint re-arms");
    endtask : t_block

    // Rate floor and margin ceiling are clamped at load; channel 3 keeps the event policy.
    task automatic t_range();
        step(1);
        cfg_wr_i <= 4'h8;
        cfg_kind_i <= KIND_RATE_RISE;
        cfg_thr_i <= 16'sh0000;
        cfg_margin_i <= 14'h3FFF;
        cfg_blk_i <= 1'b0;
        rate_i <= 16'sh0001;
        step(1);
        cfg_wr_i <= 4'h0;
        settle(3);
        cmp(state, 4'h7, "rate at clamped floor");
        step(1);
        rate_i <= 16'sh0002;
        settle(3);
        cmp(state, 4'hF, "rate above floor");
        step(1);
        rate_i <= -16'sh2710;
        settle(3);
        cmp(state, 4'h7, "margin clamped");
    endtask : t_range

    task automatic t_kinds();
        for (int k = 1; k <= 8; k++) begin
            step(1);
            cfg_wr_i <= 4'h8;
            cfg_kind_i <= alr_kind_t'(3'(k));
            step(1);
            cfg_wr_i <= 4'h0;
            settle(2);
            cmp(shown, (k == 8) ? 4'h7 : 4'hF, "visible per kind");
        end
        cmp(state, 4'h7, "unused channel stopped");
    endtask : t_kinds

    initial begin
        #100000;
        fails++;
        stop_test();
    end

    initial begin
        reset_i = 1'b1;
        pv_i = 16'sh0000;
        sp_i = 16'sh0000;
        rate_i = 16'sh0000;
        cfg_thr_i = 16'sh0064;
        cfg_margin_i = 14'h0002;
        ack_i = 4'h0;
        cfg_wr_i = 4'h0;
        cfg_kind_i = KIND_NONE;
        cfg_latch_i = LATCH_NONE;
        cfg_blk_i = 1'b0;
        cfg_done_i = 1'b0;
        nv_valid_i = 1'b0;
        restart(1'b0, 1'b0, 15, 16'sh0000);
        cmp(shown, 4'hF, "settings visible");
        t_latch();
        t_power();
        t_block();
        t_kinds();
        t_range();
        stop_test();
    end
endmodule : tb_alr_top

bind alr_top alr_top_properties i_props (
    .mclk_i(mclk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i), .cfg_kind_i(cfg_kind_i),
    .cfg_done_i(cfg_done_i), .nv_valid_i(nv_valid_i), .alarm_output_state_o(alarm_output_state_o),
    .beacon_flash_o(beacon_flash_o), .beacon_steady_o(beacon_steady_o), .message_o(message_o),
    .settings_visible_o(settings_visible_o), .suppress_armed_o(suppress_armed_o),
    .restore_busy_o(restore_busy_o)
);
